// >>> tb/serial_flash_addr_decode_por_tb.sv
// self-checking bench for the flash command framing link
`timescale 1ns/1ps
`default_nettype none
`include "sfad_defs.svh"
module serial_flash_addr_decode_por_tb;
    logic        clock_in, reset_in, por_in, start_in, mode3_in;
    logic [7:0]  opcode_in, rd_count_in, rd_data_in, cmd_opcode, rd_data;
    logic [11:0] page_in, cmd_page;
    logic [8:0]  offset_in, cmd_offset;
    logic        cmd_valid, page_used, offset_used, cmd_rmw, dev_mode3, dev_ready;
    logic        host_ready, rd_valid, done, rd_next;
    int          failures = 0;
    int          total_checks = 0;
    int          cycles = 0;

    sfad_link_if sfad_link_if_inst ();
    sfad_device #(.PUW_CYCLES(2000)) sfad_device_inst (.clock_in(clock_in),
        .reset_in(reset_in), .por_in(por_in), .link(sfad_link_if_inst),
        .rd_data_in(rd_data_in), .cmd_valid_out(cmd_valid), .cmd_opcode_out(cmd_opcode),
        .cmd_page_out(cmd_page), .cmd_offset_out(cmd_offset), .cmd_page_used_out(page_used),
        .cmd_offset_used_out(offset_used), .cmd_rmw_out(cmd_rmw), .rd_next_out(rd_next),
        .mode3_out(dev_mode3), .ready_out(dev_ready));
    sfad_host #(.VCSL_CYCLES(20), .PUW_CYCLES(2000)) sfad_host_inst (.clock_in(clock_in),
        .reset_in(reset_in), .link(sfad_link_if_inst), .start_in(start_in),
        .opcode_in(opcode_in), .page_in(page_in), .offset_in(offset_in),
        .rd_count_in(rd_count_in), .mode3_in(mode3_in), .ready_out(host_ready),
        .rd_data_out(rd_data), .rd_valid_out(rd_valid), .done_out(done));
    sfad_checker sfad_checker_inst (.clock_in(clock_in), .reset_in(reset_in),
        .chip_select_n(sfad_link_if_inst.chip_select_n), .sck(sfad_link_if_inst.sck),
        .si(sfad_link_if_inst.si), .so(sfad_link_if_inst.so),
        .so_oe(sfad_link_if_inst.so_oe), .so_line(sfad_link_if_inst.so_line));

    task automatic conclude();
        $display("checks %0d mismatches %0d", total_checks, failures);
        if (failures == 0 && total_checks > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    task automatic chk(input string nm, input logic [11:0] e, input logic [11:0] g);
        total_checks++;
        if (g !== e)
        begin
            failures++;
            $display("wrong value %s expected %h seen %h", nm, e, g);
        end
    endtask

    // one frame; fl = page used, offset used, read-modify-write
    task automatic issue(input logic [7:0] op, input logic [11:0] pg, input logic [8:0] of,
            input logic m3, input logic [7:0] n, input logic [7:0] rb, input logic [2:0] fl,
            output int nc);
        int k;
        int nr;
        int nn;
        logic fin;
        nc = 0;
        nr = 0;
        nn = 0;
        fin = 0;
        k = 0;
        while (host_ready !== 1'b1 && k < 200)
        begin
            @(posedge clock_in);
            #1;
            k++;
        end
        @(posedge clock_in);
        start_in <= 1'b1;
        opcode_in <= op;
        page_in <= pg;
        offset_in <= of;
        mode3_in <= m3;
        rd_count_in <= n;
        @(posedge clock_in);
        start_in <= 1'b0;
        for (k = 0; k < 3000 && !(fin && nc > 0); k++)
        begin
            @(posedge clock_in);
            #1;
            fin = fin | (done === 1'b1);
            if (rd_next === 1'b1)
                nn++;
            if (rd_valid === 1'b1)
            begin
                nr++;
                chk("read byte", rb, rd_data);
            end
            if (cmd_valid === 1'b1)
            begin
                nc++;
                chk("opcode", op, cmd_opcode);
                chk("page", fl[2] ? pg : 12'h0, cmd_page);
                chk("offset", fl[1] ? of : 9'h0, cmd_offset);
                chk("page used", fl[2], page_used);
                chk("offset used", fl[1], offset_used);
                chk("rmw", fl[0], cmd_rmw);
                chk("mode", m3, dev_mode3);
                if (fl[0])
                    chk("holdoff", 1'b1, dev_ready);
            end
        end
        chk("frame end", 1'b1, fin);
        chk("read count", n, nr);
        chk("byte loads", (nc == 0 || n == 0) ? 0 : n + !m3, nn);
    endtask

    task automatic t_por();
        int c;
        repeat (10) @(posedge clock_in);
        #1;
        chk("select wait", 1'b0, host_ready);
        issue(`SFAD_OP_03, 12'h123, 9'h045, 1'b0, 8'h01, 8'hff, 3'b110, c);
        chk("cmd under reset", 0, c);
        @(posedge clock_in);
        por_in <= 1'b0;
        repeat (4) @(posedge clock_in);
        #1;
        chk("early ready", 1'b0, dev_ready);
    endtask

    task automatic t_cmds();
        int c;
        issue(`SFAD_OP_58, 12'habc, 9'h1ff, 1'b0, 8'h00, 8'h00, 3'b111, c);
        chk("standby cmd", 1, c);
        issue(`SFAD_OP_59, 12'h001, 9'h100, 1'b1, 8'h00, 8'h00, 3'b111, c);
        chk("mode3 cmd", 1, c);
        issue(`SFAD_OP_1B, 12'h800, 9'h001, 1'b0, 8'h02, 8'h96, 3'b110, c);
        chk("read cmd", 1, c);
        issue(`SFAD_OP_D2, 12'h5a5, 9'h0f0, 1'b1, 8'h01, 8'h96, 3'b110, c);
        chk("long dummy cmd", 1, c);
        issue(`SFAD_OP_53, 12'h7ff, 9'h1ff, 1'b1, 8'h00, 8'h00, 3'b100, c);
        issue(`SFAD_OP_84, 12'hfff, 9'h0aa, 1'b0, 8'h00, 8'h00, 3'b010, c);
        issue(`SFAD_OP_9F, 12'h000, 9'h000, 1'b1, 8'h01, 8'h96, 3'b000, c);
        chk("no address cmd", 1, c);
    endtask

    initial
    begin
        clock_in = 1'b0;
        forever #5 clock_in = ~clock_in;
    end

    always @(posedge clock_in)
    begin
        cycles <= cycles + 1;
        if (cycles == 60000)
        begin
            failures++;
            conclude();
        end
    end

    initial
    begin
        reset_in = 1'b1;
        por_in = 1'b1;
        start_in = 1'b0;
        mode3_in = 1'b0;
        opcode_in = 8'h00;
        rd_count_in = 8'h00;
        rd_data_in = 8'h96;
        page_in = 12'h000;
        offset_in = 9'h000;
        repeat (4) @(posedge clock_in);
        reset_in <= 1'b0;
        t_por();
        t_cmds();
        conclude();
    end
endmodule
`default_nettype wire

// >>> tb/sfad_checker.sv
// assertions on the serial link between host and flash device
`timescale 1ns/1ps
`default_nettype none
module sfad_checker (
    input wire logic clock_in,
    input wire logic reset_in,
    input wire logic chip_select_n,
    input wire logic sck,
    input wire logic si,
    input wire logic so,
    input wire logic so_oe,
    input wire logic so_line
);
    default clocking cb @(posedge clock_in);
    endclocking
    default disable iff (reset_in);
    sequence s_lead;
        (!chip_select_n && $stable(sck))[*4];
    endsequence
    sequence s_high;
        sck[*8];
    endsequence
    AST_RESET_EXIT: assert property ($fell(reset_in) |-> !so_oe && chip_select_n && !sck)
        else $error("link not idle after reset");
    AST_SELECT_LEAD: assert property ($fell(chip_select_n) |-> s_lead)
        else $error("clock moved right after select fall");
    AST_SCK_HIGH: assert property ($rose(sck) && !chip_select_n |-> s_high)
        else $error("clock high phase too short");
    AST_SI_HOLD: assert property (!chip_select_n && sck && $past(sck) |-> $stable(si))
        else $error("serial input moved while clock high");
    AST_SO_QUIET: assert property (chip_select_n[*6] |-> !so_oe)
        else $error("output driven while deselected");
    AST_SO_RELEASE: assert property ($rose(chip_select_n) |-> ##[1:5] !so_oe)
        else $error("output not released after deselect");
    AST_SO_START: assert property ($rose(so_oe) |-> !chip_select_n && !sck)
        else $error("output enabled outside clock low phase");
    AST_PULLUP: assert property ($fell(chip_select_n) |-> !so_oe && so_line)
        else $error("output driven at frame start");
    AST_DRIVE: assert property (so_oe && sck && $past(sck) |-> $stable(so))
        else $error("output moved while clock high");
endmodule
`default_nettype wire

// >>> verilog/sfad_defs.svh
// constants for the flash command framing link
`ifndef SFAD_DEFS_SVH
`define SFAD_DEFS_SVH
`define SFAD_OPC_W      8
`define SFAD_ADDR_W     24
`define SFAD_PAGE_MSB   20
`define SFAD_PAGE_LSB   9
`define SFAD_OFS_MSB    8
`define SFAD_PAGE_W     12
`define SFAD_OFS_W      9
`define SFAD_RSV_W      3
`define SFAD_CLK_NS     10
`define SFAD_SCK_HALF   8
`define SFAD_VCSL_US    70
`define SFAD_VCSL_CYC   ((`SFAD_VCSL_US * 1000 + `SFAD_CLK_NS - 1) / `SFAD_CLK_NS)
`define SFAD_PUW_MS     3
`define SFAD_PUW_CYC    ((`SFAD_PUW_MS * 1000000) / `SFAD_CLK_NS)
`define SFAD_OP_01      8'h01
`define SFAD_OP_02      8'h02
`define SFAD_OP_03      8'h03
`define SFAD_OP_0B      8'h0b
`define SFAD_OP_1B      8'h1b
`define SFAD_OP_50      8'h50
`define SFAD_OP_53      8'h53
`define SFAD_OP_55      8'h55
`define SFAD_OP_58      8'h58
`define SFAD_OP_59      8'h59
`define SFAD_OP_60      8'h60
`define SFAD_OP_61      8'h61
`define SFAD_OP_79      8'h79
`define SFAD_OP_7C      8'h7c
`define SFAD_OP_81      8'h81
`define SFAD_OP_82      8'h82
`define SFAD_OP_83      8'h83
`define SFAD_OP_84      8'h84
`define SFAD_OP_85      8'h85
`define SFAD_OP_86      8'h86
`define SFAD_OP_87      8'h87
`define SFAD_OP_88      8'h88
`define SFAD_OP_89      8'h89
`define SFAD_OP_9F      8'h9f
`define SFAD_OP_AB      8'hab
`define SFAD_OP_B9      8'hb9
`define SFAD_OP_D1      8'hd1
`define SFAD_OP_D2      8'hd2
`define SFAD_OP_D3      8'hd3
`define SFAD_OP_D4      8'hd4
`define SFAD_OP_D6      8'hd6
`define SFAD_OP_D7      8'hd7
`define SFAD_DUMMY_1    3'h1
`define SFAD_DUMMY_2    3'h2
`define SFAD_DUMMY_4    3'h4
`endif

// >>> verilog/sfad_device.sv
// flash device end: command and address framing, power-on behaviour
`timescale 1ns/1ps
`default_nettype none
`include "sfad_defs.svh"
module sfad_device #(
    parameter int unsigned PUW_CYCLES = `SFAD_PUW_CYC
) (
    input  wire logic                     clock_in,
    input  wire logic                     reset_in,
    input  wire logic                     por_in,
    sfad_link_if.device                   link,
    input  wire logic [7:0]               rd_data_in,
    output logic                          cmd_valid_out,
    output logic [7:0]                    cmd_opcode_out,
    output logic [`SFAD_PAGE_W-1:0]       cmd_page_out,
    output logic [`SFAD_OFS_W-1:0]        cmd_offset_out,
    output logic                          cmd_page_used_out,
    output logic                          cmd_offset_used_out,
    output logic                          cmd_rmw_out,
    output logic                          rd_next_out,
    output logic                          mode3_out,
    output logic                          ready_out
);
    // input synchronisers
    logic cs_s1, cs_s2, cs_s3, sck_s1, sck_s2, sck_s3, si_s1, si_s2, por_s1, por_s2;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            {cs_s1, cs_s2, cs_s3} <= 3'h7;
            {sck_s1, sck_s2, sck_s3} <= 3'h0;
            {si_s1, si_s2} <= 2'h0;
            {por_s1, por_s2} <= 2'h3;
        end
        else
        begin
            {cs_s1, cs_s2, cs_s3} <= {link.chip_select_n, cs_s1, cs_s2};
            {sck_s1, sck_s2, sck_s3} <= {link.sck, sck_s1, sck_s2};
            {si_s1, si_s2} <= {link.si, si_s1};
            {por_s1, por_s2} <= {por_in, por_s1};
        end
    end

    logic armed_r, armed_nxt;
    logic cs_fall, cs_rise, sck_rise, sck_fall;
    always_comb
    begin
        armed_nxt = por_s2 ? 1'b0 : (armed_r | cs_s2);
        cs_fall = armed_r & cs_s3 & ~cs_s2 & ~por_s2;
        cs_rise = cs_s2 & ~cs_s3;
        sck_rise = sck_s2 & ~sck_s3;
        sck_fall = ~sck_s2 & sck_s3;
    end

    // program/erase holdoff after power-on
    logic [18:0] hcnt_r, hcnt_nxt;
    logic        hdone_r, hdone_nxt;
    always_comb
    begin
        hcnt_nxt = hcnt_r;
        hdone_nxt = hdone_r;
        if (por_s2)
        begin
            hcnt_nxt = '0;
            hdone_nxt = 1'b0;
        end
        else if (!hdone_r)
        begin
            hcnt_nxt = hcnt_r + 19'h1;
            hdone_nxt = (hcnt_r >= 19'(PUW_CYCLES - 1));
        end
    end

    // frame state machine
    sfad_pkg::sfad_dev_e st_r, st_nxt;
    sfad_pkg::sfad_cls_s cls_r, cls_nxt;
    logic [31:0] sh_r, sh_nxt;
    logic [4:0]  bit_r, bit_nxt;
    logic [2:0]  dcnt_r, dcnt_nxt;
    logic [7:0]  opc_r, opc_nxt, ob_r, ob_nxt;
    logic [2:0]  obit_r, obit_nxt;
    logic        so_r, so_nxt, oe_r, oe_nxt, m3_r, m3_nxt, rdn_r, rdn_nxt, issue;

    function automatic sfad_pkg::sfad_dev_e after_addr(input sfad_pkg::sfad_cls_s c);
        if (!c.is_rd)
            return sfad_pkg::DV_DONE;
        else if (c.dummy != 3'h0)
            return sfad_pkg::DV_DUMMY;
        else
            return sfad_pkg::DV_OUT;
    endfunction

    always_comb
    begin
        st_nxt = st_r;
        cls_nxt = cls_r;
        sh_nxt = sh_r;
        bit_nxt = bit_r;
        dcnt_nxt = dcnt_r;
        opc_nxt = opc_r;
        ob_nxt = ob_r;
        obit_nxt = obit_r;
        so_nxt = so_r;
        oe_nxt = oe_r;
        m3_nxt = m3_r;
        rdn_nxt = 1'b0;
        issue = 1'b0;
        unique case (st_r)
            sfad_pkg::DV_STANDBY:
                if (cs_fall)
                begin
                    st_nxt = sfad_pkg::DV_OPC;
                    bit_nxt = '0;
                    m3_nxt = sck_s2;
                end
            sfad_pkg::DV_OPC:
                if (sck_rise)
                begin
                    sh_nxt = {sh_r[30:0], si_s2};
                    bit_nxt = bit_r + 5'h1;
                    if (bit_r == 5'(`SFAD_OPC_W - 1))
                    begin
                        opc_nxt = sh_nxt[7:0];
                        cls_nxt = sfad_pkg::opc_class(sh_nxt[7:0]);
                        dcnt_nxt = cls_nxt.dummy;
                        bit_nxt = '0;
                        if (cls_nxt.has_addr)
                            st_nxt = sfad_pkg::DV_ADDR;
                        else
                        begin
                            issue = 1'b1;
                            st_nxt = after_addr(cls_nxt);
                        end
                    end
                end
            sfad_pkg::DV_ADDR:
                if (sck_rise)
                begin
                    sh_nxt = {sh_r[30:0], si_s2};
                    bit_nxt = bit_r + 5'h1;
                    if (bit_r == 5'(`SFAD_ADDR_W - 1))
                    begin
                        issue = 1'b1;
                        bit_nxt = '0;
                        st_nxt = after_addr(cls_r);
                    end
                end
            sfad_pkg::DV_DUMMY:
                if (sck_rise)
                begin
                    bit_nxt = bit_r + 5'h1;
                    if (bit_r[2:0] == 3'h7)
                    begin
                        dcnt_nxt = dcnt_r - 3'h1;
                        if (dcnt_r == 3'h1)
                            st_nxt = sfad_pkg::DV_OUT;
                    end
                end
            sfad_pkg::DV_OUT:
                if (sck_fall)
                begin
                    oe_nxt = 1'b1;
                    if (obit_r == 3'h0)
                    begin
                        so_nxt = rd_data_in[7];
                        ob_nxt = {rd_data_in[6:0], 1'b0};
                        obit_nxt = 3'h7;
                        rdn_nxt = 1'b1;
                    end
                    else
                    begin
                        so_nxt = ob_r[7];
                        ob_nxt = {ob_r[6:0], 1'b0};
                        obit_nxt = obit_r - 3'h1;
                    end
                end
            sfad_pkg::DV_DONE:
                st_nxt = st_r;
        endcase
        if (cs_rise || por_s2)
        begin
            st_nxt = sfad_pkg::DV_STANDBY;
            oe_nxt = 1'b0;
            obit_nxt = 3'h0;
        end
    end

    // command hand-off to the array side
    logic                    cv_r, cv_nxt, pend_r, pend_nxt, pu_r, pu_nxt, ou_r, ou_nxt;
    logic                    rmw_r, rmw_nxt;
    logic [7:0]              co_r, co_nxt;
    logic [`SFAD_PAGE_W-1:0] pg_r, pg_nxt;
    logic [`SFAD_OFS_W-1:0]  of_r, of_nxt;
    always_comb
    begin
        cv_nxt = 1'b0;
        pend_nxt = pend_r;
        co_nxt = co_r;
        pg_nxt = pg_r;
        of_nxt = of_r;
        pu_nxt = pu_r;
        ou_nxt = ou_r;
        rmw_nxt = rmw_r;
        if (issue)
        begin
            co_nxt = opc_nxt;
            pu_nxt = cls_nxt.has_page;
            ou_nxt = cls_nxt.has_ofs;
            rmw_nxt = cls_nxt.is_rmw;
            // reserved bits dropped; unused page or offset positions forced to zero
            pg_nxt = cls_nxt.has_page ? sh_nxt[`SFAD_PAGE_MSB:`SFAD_PAGE_LSB] : '0;
            of_nxt = cls_nxt.has_ofs ? sh_nxt[`SFAD_OFS_MSB:0] : '0;
            if (cls_nxt.is_pe && !hdone_r)
                pend_nxt = 1'b1;
            else
                cv_nxt = 1'b1;
        end
        else if (pend_r && hdone_r)
        begin
            cv_nxt = 1'b1;
            pend_nxt = 1'b0;
        end
        if (por_s2)
        begin
            cv_nxt = 1'b0;
            pend_nxt = 1'b0;
        end
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            armed_r <= 1'b0;
            hcnt_r <= '0;
            hdone_r <= 1'b0;
            st_r <= sfad_pkg::DV_STANDBY;
            cls_r <= '0;
            sh_r <= '0;
            bit_r <= '0;
            dcnt_r <= '0;
            opc_r <= '0;
            ob_r <= '0;
            obit_r <= '0;
            so_r <= 1'b0;
            oe_r <= 1'b0;
            m3_r <= 1'b0;
            rdn_r <= 1'b0;
            cv_r <= 1'b0;
            pend_r <= 1'b0;
            co_r <= '0;
            pg_r <= '0;
            of_r <= '0;
            pu_r <= 1'b0;
            ou_r <= 1'b0;
            rmw_r <= 1'b0;
        end
        else
        begin
            armed_r <= armed_nxt;
            hcnt_r <= hcnt_nxt;
            hdone_r <= hdone_nxt;
            st_r <= st_nxt;
            cls_r <= cls_nxt;
            sh_r <= sh_nxt;
            bit_r <= bit_nxt;
            dcnt_r <= dcnt_nxt;
            opc_r <= opc_nxt;
            ob_r <= ob_nxt;
            obit_r <= obit_nxt;
            so_r <= so_nxt;
            oe_r <= oe_nxt;
            m3_r <= m3_nxt;
            rdn_r <= rdn_nxt;
            cv_r <= cv_nxt;
            pend_r <= pend_nxt;
            co_r <= co_nxt;
            pg_r <= pg_nxt;
            of_r <= of_nxt;
            pu_r <= pu_nxt;
            ou_r <= ou_nxt;
            rmw_r <= rmw_nxt;
        end
    end

    assign link.so = so_r;
    assign link.so_oe = oe_r;
    assign cmd_valid_out = cv_r;
    assign cmd_opcode_out = co_r;
    assign cmd_page_out = pg_r;
    assign cmd_offset_out = of_r;
    assign cmd_page_used_out = pu_r;
    assign cmd_offset_used_out = ou_r;
    assign cmd_rmw_out = rmw_r;
    assign rd_next_out = rdn_r;
    assign mode3_out = m3_r;
    assign ready_out = hdone_r;
endmodule
`default_nettype wire

// >>> verilog/sfad_host.sv
// host controller end: issues opcode, address, dummy bytes and reads data
`timescale 1ns/1ps
`default_nettype none
`include "sfad_defs.svh"
module sfad_host #(
    parameter int unsigned VCSL_CYCLES = `SFAD_VCSL_CYC,
    parameter int unsigned PUW_CYCLES  = `SFAD_PUW_CYC
) (
    input  wire logic                     clock_in,
    input  wire logic                     reset_in,
    sfad_link_if.host                     link,
    input  wire logic                     start_in,
    input  wire logic [7:0]               opcode_in,
    input  wire logic [`SFAD_PAGE_W-1:0]  page_in,
    input  wire logic [`SFAD_OFS_W-1:0]   offset_in,
    input  wire logic [7:0]               rd_count_in,
    input  wire logic                     mode3_in,
    output logic                          ready_out,
    output logic [7:0]                    rd_data_out,
    output logic                          rd_valid_out,
    output logic                          done_out
);
    logic so_s1, so_s2;
    always_ff @(posedge clock_in)
    begin
        if (reset_in)
            {so_s1, so_s2} <= 2'h3;
        else
            {so_s1, so_s2} <= {link.so_line, so_s1};
    end

    sfad_pkg::sfad_host_e st_r, st_nxt;
    sfad_pkg::sfad_cls_s  cls;
    logic [12:0] vcnt_r, vcnt_nxt;
    logic [18:0] pcnt_r, pcnt_nxt;
    logic [2:0]  hc_r, hc_nxt;
    logic [31:0] tx_r, tx_nxt;
    logic [11:0] cnt_r, cnt_nxt, tot_r, tot_nxt, rxf_r, rxf_nxt, rxi;
    logic [7:0]  rx_r, rx_nxt;
    logic        pe_r, pe_nxt, cs_r, cs_nxt, sck_r, sck_nxt, si_r, si_nxt, m3_r, m3_nxt;
    logic        rv_r, rv_nxt, dn_r, dn_nxt, rdy_r, rdy_nxt, tick;

    always_comb
    begin
        st_nxt = st_r;
        cls = sfad_pkg::opc_class(opcode_in);
        vcnt_nxt = vcnt_r;
        pcnt_nxt = (pcnt_r >= 19'(PUW_CYCLES)) ? pcnt_r : pcnt_r + 19'h1;
        tick = (hc_r == 3'(`SFAD_SCK_HALF - 1));
        hc_nxt = tick ? 3'h0 : hc_r + 3'h1;
        tx_nxt = tx_r;
        cnt_nxt = cnt_r;
        tot_nxt = tot_r;
        rxf_nxt = rxf_r;
        rxi = cnt_r - rxf_r;
        rx_nxt = rx_r;
        pe_nxt = pe_r;
        cs_nxt = cs_r;
        sck_nxt = sck_r;
        si_nxt = si_r;
        m3_nxt = m3_r;
        rv_nxt = 1'b0;
        dn_nxt = 1'b0;
        unique case (st_r)
            sfad_pkg::HS_POWER:
                if (vcnt_r >= 13'(VCSL_CYCLES - 1))
                    st_nxt = sfad_pkg::HS_IDLE;
                else
                    vcnt_nxt = vcnt_r + 13'h1;
            sfad_pkg::HS_IDLE:
                if (start_in)
                begin
                    m3_nxt = mode3_in;
                    sck_nxt = mode3_in;
                    pe_nxt = cls.is_pe;
                    // reserved bits driven high, the device must ignore them
                    tx_nxt = cls.has_addr ? {opcode_in, {`SFAD_RSV_W{1'b1}}, page_in, offset_in}
                                          : {opcode_in, 24'h0};
                    rxf_nxt = (cls.has_addr ? 12'h020 : 12'h008) + {6'h0, cls.dummy, 3'h0};
                    tot_nxt = rxf_nxt + {1'b0, rd_count_in, 3'h0};
                    cnt_nxt = '0;
                    st_nxt = sfad_pkg::HS_HOLD;
                end
            sfad_pkg::HS_HOLD:
                if (!pe_r || pcnt_r >= 19'(PUW_CYCLES))
                begin
                    st_nxt = sfad_pkg::HS_LEAD;
                    hc_nxt = 3'h0;
                end
            sfad_pkg::HS_LEAD:
                if (tick)
                begin
                    cs_nxt = 1'b0;
                    if (!m3_r)
                    begin
                        si_nxt = tx_r[31];
                        tx_nxt = {tx_r[30:0], 1'b0};
                    end
                    st_nxt = sfad_pkg::HS_SHIFT;
                end
            sfad_pkg::HS_SHIFT:
                if (tick && !sck_r)
                begin
                    sck_nxt = 1'b1;
                    cnt_nxt = cnt_r + 12'h1;
                    if (cnt_r >= rxf_r)
                    begin
                        rx_nxt = {rx_r[6:0], so_s2};
                        rv_nxt = (rxi[2:0] == 3'h7);
                    end
                    if (cnt_nxt == tot_r)
                        st_nxt = sfad_pkg::HS_TAIL;
                end
                else if (tick)
                begin
                    sck_nxt = 1'b0;
                    si_nxt = tx_r[31];
                    tx_nxt = {tx_r[30:0], 1'b0};
                end
            sfad_pkg::HS_TAIL:
                if (tick)
                begin
                    sck_nxt = m3_r;
                    st_nxt = sfad_pkg::HS_GAP;
                end
            sfad_pkg::HS_GAP:
                if (tick)
                begin
                    cs_nxt = 1'b1;
                    dn_nxt = 1'b1;
                    st_nxt = sfad_pkg::HS_IDLE;
                end
        endcase
        rdy_nxt = (st_nxt == sfad_pkg::HS_IDLE);
    end

    always_ff @(posedge clock_in)
    begin
        if (reset_in)
        begin
            st_r <= sfad_pkg::HS_POWER;
            vcnt_r <= '0;
            pcnt_r <= '0;
            hc_r <= '0;
            tx_r <= '0;
            cnt_r <= '0;
            tot_r <= '0;
            rxf_r <= '0;
            rx_r <= '0;
            pe_r <= 1'b0;
            cs_r <= 1'b1;
            sck_r <= 1'b0;
            si_r <= 1'b0;
            m3_r <= 1'b0;
            rv_r <= 1'b0;
            dn_r <= 1'b0;
            rdy_r <= 1'b0;
        end
        else
        begin
            st_r <= st_nxt;
            vcnt_r <= vcnt_nxt;
            pcnt_r <= pcnt_nxt;
            hc_r <= hc_nxt;
            tx_r <= tx_nxt;
            cnt_r <= cnt_nxt;
            tot_r <= tot_nxt;
            rxf_r <= rxf_nxt;
            rx_r <= rx_nxt;
            pe_r <= pe_nxt;
            cs_r <= cs_nxt;
            sck_r <= sck_nxt;
            si_r <= si_nxt;
            m3_r <= m3_nxt;
            rv_r <= rv_nxt;
            dn_r <= dn_nxt;
            rdy_r <= rdy_nxt;
        end
    end

    assign link.chip_select_n = cs_r;
    assign link.sck = sck_r;
    assign link.si = si_r;
    assign ready_out = rdy_r;
    assign rd_data_out = rx_r;
    assign rd_valid_out = rv_r;
    assign done_out = dn_r;
endmodule
`default_nettype wire

// >>> verilog/sfad_link_if.sv
// serial link between host controller and flash device
`timescale 1ns/1ps
`default_nettype none
interface sfad_link_if;
    logic chip_select_n;
    logic sck;
    logic si;
    logic so;
    logic so_oe;
    logic so_line;

    // released serial output reads as pulled high
    assign so_line = so_oe ? so : 1'b1;

    modport host (output chip_select_n, output sck, output si, input so_line);
    modport device (input chip_select_n, input sck, input si, output so, output so_oe);
endinterface
`default_nettype wire

// >>> verilog/sfad_pkg.sv
// types and opcode classification for the flash command framing link
`include "sfad_defs.svh"
package sfad_pkg;
    typedef struct packed {
        logic       has_addr;
        logic       has_page;
        logic       has_ofs;
        logic       is_rd;
        logic       is_pe;
        logic       is_rmw;
        logic [2:0] dummy;
    } sfad_cls_s;

    typedef enum logic [2:0] {DV_STANDBY, DV_OPC, DV_ADDR, DV_DUMMY, DV_OUT, DV_DONE} sfad_dev_e;
    typedef enum logic [2:0] {HS_POWER, HS_IDLE, HS_HOLD, HS_LEAD, HS_SHIFT, HS_TAIL,
                              HS_GAP} sfad_host_e;

    function automatic sfad_cls_s opc_class(input logic [7:0] op);
        sfad_cls_s c;
        c = '0;
        c.has_addr = !(op inside {`SFAD_OP_79, `SFAD_OP_9F, `SFAD_OP_AB, `SFAD_OP_B9,
                                  `SFAD_OP_D7});
        c.has_page = op inside {`SFAD_OP_01, `SFAD_OP_02, `SFAD_OP_03, `SFAD_OP_0B,
            `SFAD_OP_1B, `SFAD_OP_50, `SFAD_OP_53, `SFAD_OP_55, `SFAD_OP_58, `SFAD_OP_59,
            `SFAD_OP_60, `SFAD_OP_61, `SFAD_OP_7C, `SFAD_OP_81, `SFAD_OP_82, `SFAD_OP_83,
            `SFAD_OP_85, `SFAD_OP_86, `SFAD_OP_88, `SFAD_OP_89, `SFAD_OP_D2};
        c.has_ofs = op inside {`SFAD_OP_01, `SFAD_OP_02, `SFAD_OP_03, `SFAD_OP_0B,
            `SFAD_OP_1B, `SFAD_OP_58, `SFAD_OP_59, `SFAD_OP_82, `SFAD_OP_84, `SFAD_OP_85,
            `SFAD_OP_87, `SFAD_OP_D1, `SFAD_OP_D2, `SFAD_OP_D3, `SFAD_OP_D4, `SFAD_OP_D6};
        c.is_rd = op inside {`SFAD_OP_03, `SFAD_OP_0B, `SFAD_OP_1B, `SFAD_OP_9F, `SFAD_OP_D1,
            `SFAD_OP_D2, `SFAD_OP_D3, `SFAD_OP_D4, `SFAD_OP_D6, `SFAD_OP_D7};
        c.is_pe = op inside {`SFAD_OP_02, `SFAD_OP_50, `SFAD_OP_58, `SFAD_OP_59, `SFAD_OP_7C,
            `SFAD_OP_81, `SFAD_OP_82, `SFAD_OP_83, `SFAD_OP_85, `SFAD_OP_86, `SFAD_OP_88,
            `SFAD_OP_89};
        c.is_rmw = op inside {`SFAD_OP_58, `SFAD_OP_59};
        if (op inside {`SFAD_OP_0B, `SFAD_OP_D4, `SFAD_OP_D6})
            c.dummy = `SFAD_DUMMY_1;
        else if (op == `SFAD_OP_1B)
            c.dummy = `SFAD_DUMMY_2;
        else if (op == `SFAD_OP_D2)
            c.dummy = `SFAD_DUMMY_4;
        return c;
    endfunction
endpackage
